// ---- hdl/pcm_pkg.sv ----
// Constants for the power and clock manager
package pcm_pkg;

  // Register byte offsets
  localparam logic [7:0] PCM_CGMR_OFS = 8'h00;
  localparam logic [7:0] PCM_MODE_OFS = 8'h04;
  localparam logic [7:0] PCM_SR_OFS = 8'h08;
  localparam logic [7:0] PCM_ISR_OFS = 8'h0C;
  localparam logic [7:0] PCM_IMR_OFS = 8'h10;
  localparam logic [7:0] PCM_PCER_OFS = 8'h14;
  localparam logic [7:0] PCM_WAKE_OFS = 8'h18;

  // Clock generator mode register fields
  localparam int PCM_OSC_EN_BIT = 0;
  localparam int PCM_OSC_BYP_BIT = 1;
  localparam int PCM_OSCNT_LSB = 8;
  localparam int PCM_MUL_LSB = 16;
  localparam int PCM_CSS_LSB = 24;
  localparam int PCM_OSCNT_W = 8;
  localparam int PCM_MUL_W = 6;
  localparam int PCM_PERIPH_W = 8;

  // Clock source select codes
  localparam logic [1:0] PCM_CSS_SLOW = 2'h0;
  localparam logic [1:0] PCM_CSS_OSC = 2'h1;
  localparam logic [1:0] PCM_CSS_MUL = 2'h2;

  // Interrupt status bits
  localparam int PCM_EV_OSC = 0;
  localparam int PCM_EV_WAKE = 1;
  localparam int PCM_EV_BACKUP = 2;
  localparam int PCM_EV_W = 3;

  // Wake configuration bits
  localparam int PCM_WK_RISE_BIT = 0;
  localparam int PCM_WK_ALARM_BIT = 1;

  // Timing
  localparam int PCM_SLOW_CLK_HZ = 32768;
  localparam int PCM_BACKUP_HOLD_SLOW_CYCLES = 32768;
  localparam logic [2:0] PCM_OSC_DIV_LAST = 3'h7;

  // Mode command codes
  localparam logic [2:0] PCM_CMD_NORMAL = 3'h0;
  localparam logic [2:0] PCM_CMD_IDLE = 3'h1;
  localparam logic [2:0] PCM_CMD_SLOW = 3'h2;
  localparam logic [2:0] PCM_CMD_STANDBY = 3'h3;
  localparam logic [2:0] PCM_CMD_PDOWN = 3'h4;

  typedef enum logic [2:0] {
    PCM_NORMAL,
    PCM_IDLE,
    PCM_SLOW,
    PCM_STANDBY,
    PCM_PDOWN
  } pcm_mode_e;

endpackage

// ---- hdl/pcm_power_clock_manager.sv ----
// Power and clock manager with Wishbone register access
//
// The Wishbone slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pcm_power_clock_manager
  import pcm_pkg::*;
#(
  parameter int BACKUP_HOLD_CYCLES = PCM_BACKUP_HOLD_SLOW_CYCLES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic slow_clk_pin,
  input wire logic backup_reset_pin,
  input wire logic osc_amp_clk,
  input wire logic osc_input_pin,
  input wire logic multiplier_clk,
  input wire logic wakeup_pin,
  input wire logic rtc_alarm,
  input wire logic irq_pending,
  output logic backup_reset_n,
  output logic main_power_on,
  output logic core_clk_run,
  output logic [7:0] periph_clk_run,
  output logic main_osc_run,
  output logic osc_amp_enable,
  output logic multiplier_enable,
  output logic [6:0] multiplier_ratio,
  output logic master_clock_output_pin,
  output logic irq
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] slow_sync_reg, bkp_sync_reg, wake_sync_reg, alarm_sync_reg, amp_sync_reg, xin_sync_reg, mul_sync_reg;
  logic slow_prev_reg, wake_prev_reg, alarm_prev_reg, slow_tick;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      slow_sync_reg <= 2'h0;
      bkp_sync_reg <= 2'h0;
      wake_sync_reg <= 2'h0;
      alarm_sync_reg <= 2'h0;
      amp_sync_reg <= 2'h0;
      xin_sync_reg <= 2'h0;
      mul_sync_reg <= 2'h0;
      slow_prev_reg <= 1'b0;
      wake_prev_reg <= 1'b0;
      alarm_prev_reg <= 1'b0;
    end else begin
      slow_sync_reg <= {slow_sync_reg[0], slow_clk_pin};
      bkp_sync_reg <= {bkp_sync_reg[0], backup_reset_pin};
      wake_sync_reg <= {wake_sync_reg[0], wakeup_pin};
      alarm_sync_reg <= {alarm_sync_reg[0], rtc_alarm};
      amp_sync_reg <= {amp_sync_reg[0], osc_amp_clk};
      xin_sync_reg <= {xin_sync_reg[0], osc_input_pin};
      mul_sync_reg <= {mul_sync_reg[0], multiplier_clk};
      slow_prev_reg <= slow_sync_reg[1];
      wake_prev_reg <= wake_sync_reg[1];
      alarm_prev_reg <= alarm_sync_reg[1];
    end
  end

  // Rising edge of the permanent slow clock paces all slow timing
  assign slow_tick = slow_sync_reg[1] & ~slow_prev_reg;

  // ----------------------------------------------------------------
  // Backup reset stretcher
  // ----------------------------------------------------------------
  logic [16:0] bkp_cnt_reg;
  logic bkp_rel_reg;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bkp_cnt_reg <= 17'h00000;
      bkp_rel_reg <= 1'b0;
    end else if (!bkp_sync_reg[1]) begin
      bkp_cnt_reg <= 17'h00000;
      bkp_rel_reg <= 1'b0;
    end else if (!bkp_rel_reg && slow_tick) begin
      if (bkp_cnt_reg == 17'(BACKUP_HOLD_CYCLES - 1)) begin
        bkp_rel_reg <= 1'b1;
      end
      bkp_cnt_reg <= bkp_cnt_reg + 17'h00001;
    end
  end

  // Battery-domain logic is held until the slow oscillator has settled
  assign backup_reset_n = bkp_rel_reg;

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  logic req, wr, rd;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i;
  assign rd = req & ~wb_we_i;

  function automatic logic hit(input logic [7:0] ofs, input logic [7:0] adr);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic osc_en_reg, osc_byp_reg;
  logic [7:0] oscnt_reg, pcer_reg;
  logic [5:0] mul_reg;
  logic [1:0] css_reg, wake_cfg_reg;
  logic [2:0] imr_reg;
  logic cgmr_wr, mode_wr, slow_cmd;

  assign cgmr_wr = wr & hit(PCM_CGMR_OFS, wb_adr_i) & wb_sel_i[0];
  assign mode_wr = wr & hit(PCM_MODE_OFS, wb_adr_i) & wb_sel_i[0];
  assign slow_cmd = mode_wr & (wb_dat_i[2:0] == PCM_CMD_SLOW);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      osc_en_reg <= 1'b0;
      osc_byp_reg <= 1'b0;
      oscnt_reg <= 8'h00;
      mul_reg <= 6'h00;
      css_reg <= PCM_CSS_SLOW;
    end else if (slow_cmd) begin
      osc_en_reg <= 1'b0;
      mul_reg <= 6'h00;
      css_reg <= PCM_CSS_SLOW;
    end else if (cgmr_wr) begin
      osc_en_reg <= wb_dat_i[PCM_OSC_EN_BIT];
      osc_byp_reg <= wb_dat_i[PCM_OSC_BYP_BIT];
      oscnt_reg <= wb_dat_i[PCM_OSCNT_LSB +: PCM_OSCNT_W];
      if (wb_sel_i[2]) begin
        mul_reg <= wb_dat_i[PCM_MUL_LSB +: PCM_MUL_W];
      end
      if (wb_sel_i[3]) begin
        css_reg <= wb_dat_i[PCM_CSS_LSB +: 2];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pcer_reg <= 8'h00;
      wake_cfg_reg <= 2'h1;
      imr_reg <= 3'h0;
    end else if (wr && wb_sel_i[0]) begin
      if (hit(PCM_PCER_OFS, wb_adr_i)) begin
        pcer_reg <= wb_dat_i[PCM_PERIPH_W-1:0];
      end
      if (hit(PCM_WAKE_OFS, wb_adr_i)) begin
        wake_cfg_reg <= wb_dat_i[1:0];
      end
      if (hit(PCM_IMR_OFS, wb_adr_i)) begin
        imr_reg <= wb_dat_i[PCM_EV_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Oscillator start-up counter
  // ----------------------------------------------------------------
  logic [7:0] osc_cnt_reg;
  logic [2:0] osc_div_reg;
  logic osc_counting_reg, osc_stable_reg, osc_done;

  assign osc_done = osc_counting_reg & slow_tick & (osc_div_reg == PCM_OSC_DIV_LAST) & (osc_cnt_reg == 8'h00);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      osc_cnt_reg <= 8'h00;
      osc_div_reg <= 3'h0;
      osc_counting_reg <= 1'b0;
      osc_stable_reg <= 1'b0;
    end else if (slow_cmd || (cgmr_wr && !wb_dat_i[PCM_OSC_EN_BIT])) begin
      osc_counting_reg <= 1'b0;
      osc_stable_reg <= 1'b0;
    end else if (cgmr_wr) begin
      osc_cnt_reg <= wb_dat_i[PCM_OSCNT_LSB +: PCM_OSCNT_W];
      osc_div_reg <= 3'h0;
      osc_counting_reg <= 1'b1;
      osc_stable_reg <= 1'b0;
    end else if (osc_counting_reg && slow_tick) begin
      osc_div_reg <= osc_div_reg + 3'h1;
      if (osc_div_reg == PCM_OSC_DIV_LAST) begin
        if (osc_cnt_reg == 8'h00) begin
          osc_counting_reg <= 1'b0;
          osc_stable_reg <= 1'b1;
        end else begin
          osc_cnt_reg <= osc_cnt_reg - 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Operating mode sequencer
  // ----------------------------------------------------------------
  pcm_mode_e mode_reg;
  logic wake_edge, alarm_edge, pd_wake;

  assign wake_edge = wake_cfg_reg[PCM_WK_RISE_BIT] ? (wake_sync_reg[1] & ~wake_prev_reg)
                                                   : (~wake_sync_reg[1] & wake_prev_reg);
  assign alarm_edge = wake_cfg_reg[PCM_WK_ALARM_BIT] & alarm_sync_reg[1] & ~alarm_prev_reg;
  assign pd_wake = (mode_reg == PCM_PDOWN) & (wake_edge | alarm_edge);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg <= PCM_SLOW;
    end else begin
      case (mode_reg)
        PCM_IDLE: mode_reg <= irq_pending ? PCM_NORMAL : PCM_IDLE;
        PCM_STANDBY: mode_reg <= irq_pending ? PCM_SLOW : PCM_STANDBY;
        PCM_PDOWN: mode_reg <= pd_wake ? PCM_SLOW : PCM_PDOWN;
        PCM_NORMAL, PCM_SLOW: begin
          if (mode_wr) begin
            case (wb_dat_i[2:0])
              PCM_CMD_NORMAL: mode_reg <= PCM_NORMAL;
              PCM_CMD_IDLE: mode_reg <= PCM_IDLE;
              PCM_CMD_SLOW: mode_reg <= PCM_SLOW;
              PCM_CMD_STANDBY: mode_reg <= PCM_STANDBY;
              PCM_CMD_PDOWN: mode_reg <= PCM_PDOWN;
              default: mode_reg <= mode_reg;
            endcase
          end
        end
        default: mode_reg <= PCM_SLOW;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock and power outputs
  // ----------------------------------------------------------------
  logic osc_out;
  logic mclk_reg;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      main_power_on <= 1'b1;
      core_clk_run <= 1'b1;
      periph_clk_run <= 8'h00;
      main_osc_run <= 1'b0;
      osc_amp_enable <= 1'b0;
      multiplier_enable <= 1'b0;
      multiplier_ratio <= 7'h01;
    end else begin
      main_power_on <= (mode_reg != PCM_PDOWN);
      core_clk_run <= (mode_reg == PCM_NORMAL) || (mode_reg == PCM_SLOW);
      periph_clk_run <= (mode_reg == PCM_PDOWN) ? 8'h00 : pcer_reg;
      main_osc_run <= osc_en_reg;
      osc_amp_enable <= osc_en_reg & ~osc_byp_reg;
      multiplier_enable <= osc_en_reg & (mul_reg != 6'h00);
      multiplier_ratio <= {1'b0, mul_reg} + 7'h01;
    end
  end

  // Bypass routes the raw input pin clock instead of the amplifier
  assign osc_out = osc_byp_reg ? xin_sync_reg[1] : amp_sync_reg[1];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mclk_reg <= 1'b0;
    end else begin
      case (css_reg)
        PCM_CSS_OSC: mclk_reg <= osc_out & osc_stable_reg;
        PCM_CSS_MUL: mclk_reg <= mul_sync_reg[1] & multiplier_enable;
        default: mclk_reg <= slow_sync_reg[1];
      endcase
    end
  end

  assign master_clock_output_pin = mclk_reg;

  // ----------------------------------------------------------------
  // Interrupt status, cleared by reading it
  // ----------------------------------------------------------------
  logic [2:0] isr_reg;
  logic [2:0] ev;
  logic bkp_rel_prev_reg;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bkp_rel_prev_reg <= 1'b0;
    end else begin
      bkp_rel_prev_reg <= bkp_rel_reg;
    end
  end

  assign ev = {bkp_rel_reg & ~bkp_rel_prev_reg, pd_wake, osc_done};

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      isr_reg <= 3'h0;
    end else if (rd && hit(PCM_ISR_OFS, wb_adr_i)) begin
      isr_reg <= ev;
    end else begin
      isr_reg <= isr_reg | ev;
    end
  end

  assign irq = |(isr_reg & imr_reg);

  // ----------------------------------------------------------------
  // Read data and acknowledge
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      if (rd) begin
        case (wb_adr_i[7:2])
          PCM_CGMR_OFS[7:2]: wb_dat_o <= {6'h00, css_reg, 2'h0, mul_reg, oscnt_reg, 6'h00, osc_byp_reg, osc_en_reg};
          PCM_MODE_OFS[7:2]: wb_dat_o <= {29'h00000000, mode_reg};
          PCM_SR_OFS[7:2]: wb_dat_o <= {26'h0000000, mode_reg, osc_counting_reg, bkp_rel_reg, osc_stable_reg};
          PCM_ISR_OFS[7:2]: wb_dat_o <= {29'h00000000, isr_reg};
          PCM_IMR_OFS[7:2]: wb_dat_o <= {29'h00000000, imr_reg};
          PCM_PCER_OFS[7:2]: wb_dat_o <= {24'h000000, pcer_reg};
          PCM_WAKE_OFS[7:2]: wb_dat_o <= {30'h00000000, wake_cfg_reg};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ---- bench/pcm_far_side.sv ----
// Far-side model: slow crystal, main crystal, multiplier and backup reset circuit
`timescale 1ns/1ps
`default_nettype none
module pcm_far_side #(
  parameter int SLOW_HALF = 5,
  parameter int BU_DELAY = 20
) (
  input wire logic core_clk,
  input wire logic osc_amp_enable,
  input wire logic multiplier_enable,
  output logic slow_clk_pin,
  output logic backup_reset_pin,
  output logic osc_amp_clk,
  output logic osc_input_pin,
  output logic multiplier_clk
);
  int cnt = 0;
  always @(posedge core_clk) begin
    cnt <= cnt + 1;
  end
  // Scaled slow clock, never stops
  assign slow_clk_pin = ((cnt / SLOW_HALF) % 2) == 1;
  assign backup_reset_pin = cnt >= BU_DELAY;
  // Crystal and multiplier stand still while not enabled
  assign osc_amp_clk = osc_amp_enable & cnt[0];
  assign multiplier_clk = multiplier_enable & cnt[1];
  assign osc_input_pin = ((cnt / 3) % 2) == 1;
endmodule
`default_nettype wire

// ---- bench/pcm_power_clock_manager_assertions.sv ----
// Port checker for the power and clock manager
`timescale 1ns/1ps
`default_nettype none
module pcm_power_clock_manager_chk
  import pcm_pkg::*;
#(
  parameter int BACKUP_HOLD_CYCLES = PCM_BACKUP_HOLD_SLOW_CYCLES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic backup_reset_pin,
  input wire logic backup_reset_n,
  input wire logic main_power_on,
  input wire logic core_clk_run,
  input wire logic [7:0] periph_clk_run,
  input wire logic main_osc_run,
  input wire logic osc_amp_enable,
  input wire logic multiplier_enable,
  input wire logic [6:0] multiplier_ratio
);
  // Cycles the backup pin has been high
  int hi_cnt;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hi_cnt <= 0;
    end else begin
      hi_cnt <= backup_reset_pin ? hi_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pin_low;
    !backup_reset_pin [*5];
  endsequence
  a_ack_answer: assert property (s_req |=> wb_ack_o) else $error("no ack after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
  a_backup_hold: assert property ($rose(backup_reset_n) |-> hi_cnt >= 4 * (BACKUP_HOLD_CYCLES - 1))
    else $error("backup reset released early");
  a_backup_pin_low: assert property (s_pin_low |-> !backup_reset_n) else $error("backup reset not held");
  a_pdown_gates: assert property (!main_power_on |-> !core_clk_run && periph_clk_run == 8'h00)
    else $error("clocks run with power off");
  a_osc_gates: assert property (!main_osc_run |-> !osc_amp_enable && !multiplier_enable)
    else $error("amplifier or multiplier on with oscillator off");
  a_mul_zero: assert property (multiplier_enable |-> multiplier_ratio != 7'h01)
    else $error("multiplier on with zero value");
  a_ratio_range: assert property (multiplier_ratio != 7'h00 && multiplier_ratio <= 7'h40)
    else $error("ratio out of range");
endmodule
bind pcm_power_clock_manager pcm_power_clock_manager_chk #(.BACKUP_HOLD_CYCLES(BACKUP_HOLD_CYCLES)) chk_i (
  .core_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .backup_reset_pin, .backup_reset_n, .main_power_on,
  .core_clk_run, .periph_clk_run, .main_osc_run, .osc_amp_enable, .multiplier_enable, .multiplier_ratio);
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the power and clock manager
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pcm_pkg::*;
;
  localparam int HOLD = 4;
  localparam int SLOW_HALF = 5;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic wakeup_pin = 1'b0;
  logic rtc_alarm = 1'b0;
  logic irq_pending = 1'b0;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, slow_clk_pin, backup_reset_pin, osc_amp_clk, osc_input_pin, multiplier_clk, irq;
  logic backup_reset_n, main_power_on, core_clk_run, main_osc_run, osc_amp_enable, multiplier_enable;
  logic master_clock_output_pin, m0;
  logic [7:0] periph_clk_run, pv;
  logic [6:0] multiplier_ratio;
  logic [15:0] lfsr = 16'h3F0D;
  logic [5:0] mv [4];
  int mismatches = 0;
  int checks = 0;
  int cyc_cnt = 0;
  int n, t0, tg, nc, e;
  pcm_power_clock_manager #(.BACKUP_HOLD_CYCLES(HOLD)) pcm_power_clock_manager_i (
    .core_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .slow_clk_pin, .backup_reset_pin, .osc_amp_clk, .osc_input_pin, .multiplier_clk, .wakeup_pin, .rtc_alarm,
    .irq_pending, .backup_reset_n, .main_power_on, .core_clk_run, .periph_clk_run, .main_osc_run,
    .osc_amp_enable, .multiplier_enable, .multiplier_ratio, .master_clock_output_pin, .irq);
  pcm_far_side #(.SLOW_HALF(SLOW_HALF), .BU_DELAY(20)) pcm_far_side_i (
    .core_clk, .osc_amp_enable, .multiplier_enable, .slow_clk_pin, .backup_reset_pin, .osc_amp_clk,
    .osc_input_pin, .multiplier_clk);
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc_cnt <= cyc_cnt + 1;
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] cgmr(input logic en, input logic byp, input logic [7:0] c, input logic [5:0] m,
                                       input logic [1:0] clock_source_select);
    return {6'h00, clock_source_select, 2'h0, m, c, 6'h00, byp, en};
  endfunction
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic guard(input int c);
    if (c >= 900) begin
      mismatches++;
      end_of_test();
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge core_clk);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge core_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 900);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    guard(k);
  endtask
  task automatic mode(input logic [2:0] c);
    xfer(1'b1, PCM_MODE_OFS, 32'(c));
    tick(4);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    tick(3);
    check(32'({main_power_on, core_clk_run, main_osc_run, backup_reset_n, periph_clk_run, multiplier_ratio}),
          32'h00060001);
    tick(3);
    rstn <= 1'b1;
    xfer(1'b1, PCM_IMR_OFS, 32'h00000007);
    xfer(1'b0, PCM_MODE_OFS, 32'h0);
    check(rd, 32'(PCM_SLOW));
    xfer(1'b0, 8'h1C, 32'h0);
    check(rd, 32'h0);
    for (n = 0; backup_reset_n !== 1'b1 && n < 900; n++) tick(1);
    guard(n);
    tick(3);
    check(32'(irq), 32'h1);
    xfer(1'b0, PCM_ISR_OFS, 32'h0);
    check(rd, 32'h00000004);
    tick(2);
    check(32'(irq), 32'h0);
    lfsr = lfsr_next(lfsr);
    nc = int'(lfsr[1:0]);
    e = 16 * SLOW_HALF * (nc + 1);
    xfer(1'b1, PCM_IMR_OFS, 32'h0);
    xfer(1'b1, PCM_CGMR_OFS, cgmr(1'b1, 1'b0, 8'(nc), 6'h00, PCM_CSS_SLOW));
    t0 = cyc_cnt;
    tick(2);
    check(32'({main_osc_run, osc_amp_enable}), 32'h3);
    rd = 32'h0;
    for (n = 0; rd[0] !== 1'b1 && n < 900; n++) xfer(1'b0, PCM_SR_OFS, 32'h0);
    guard(n);
    check(32'(cyc_cnt - t0 >= e - 12 && cyc_cnt - t0 <= e + 14), 32'h1);
    check(32'(irq), 32'h0);
    xfer(1'b0, PCM_ISR_OFS, 32'h0);
    check(rd & 32'h1, 32'h1);
    mv = '{6'h00, 6'h01, 6'h3F, lfsr[7:2]};
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, PCM_CGMR_OFS, cgmr(1'b1, 1'b0, 8'h00, mv[i], PCM_CSS_SLOW));
      tick(2);
      check(32'({multiplier_enable, multiplier_ratio}), 32'({mv[i] != 6'h00, 7'(mv[i]) + 7'h01}));
    end
    for (int c = 0; c < 3; c++) begin
      xfer(1'b1, PCM_CGMR_OFS, cgmr(1'b1, 1'b0, 8'h00, 6'h03, 2'(c)));
      tick(120);
      tg = 0;
      repeat (40) begin
        m0 = master_clock_output_pin;
        @(posedge core_clk);
        if (master_clock_output_pin !== m0) tg++;
      end
      check(32'(tg), 32'(c == 1 ? 40 : (c == 2 ? 20 : 40 / SLOW_HALF)));
    end
    xfer(1'b1, PCM_CGMR_OFS, cgmr(1'b1, 1'b1, 8'h00, 6'h00, PCM_CSS_SLOW));
    tick(2);
    check(32'({main_osc_run, osc_amp_enable}), 32'h2);
    xfer(1'b1, PCM_CGMR_OFS, cgmr(1'b0, 1'b0, 8'h00, 6'h00, PCM_CSS_SLOW));
    tick(2);
    check(32'(main_osc_run), 32'h0);
    xfer(1'b0, PCM_SR_OFS, 32'h0);
    check(rd & 32'h1, 32'h0);
    lfsr = lfsr_next(lfsr);
    pv = lfsr[7:0];
    xfer(1'b1, PCM_PCER_OFS, 32'(pv));
    mode(3'h7);
    xfer(1'b0, PCM_MODE_OFS, 32'h0);
    check(rd, 32'(PCM_SLOW));
    mode(PCM_CMD_NORMAL);
    check(32'({core_clk_run, periph_clk_run}), 32'({1'b1, pv}));
    mode(PCM_CMD_IDLE);
    check(32'({core_clk_run, periph_clk_run}), 32'({1'b0, pv}));
    irq_pending <= 1'b1;
    tick(4);
    irq_pending <= 1'b0;
    xfer(1'b0, PCM_MODE_OFS, 32'h0);
    check(rd, 32'(PCM_NORMAL));
    xfer(1'b1, PCM_CGMR_OFS, cgmr(1'b1, 1'b0, 8'h00, 6'h00, PCM_CSS_SLOW));
    mode(PCM_CMD_SLOW);
    check(32'({main_osc_run, core_clk_run}), 32'h1);
    mode(PCM_CMD_STANDBY);
    check(32'(core_clk_run), 32'h0);
    irq_pending <= 1'b1;
    tick(4);
    irq_pending <= 1'b0;
    xfer(1'b0, PCM_MODE_OFS, 32'h0);
    check(rd, 32'(PCM_SLOW));
    for (int w = 0; w < 3; w++) begin
      xfer(1'b1, PCM_WAKE_OFS, 32'(w == 1 ? 3 : (w == 0 ? 1 : 0)));
      mode(PCM_CMD_PDOWN);
      check(32'({main_power_on, core_clk_run, periph_clk_run}), 32'h0);
      if (w == 1) rtc_alarm <= 1'b1;
      else wakeup_pin <= (w == 0);
      for (n = 0; main_power_on !== 1'b1 && n < 900; n++) tick(1);
      guard(n);
      xfer(1'b0, PCM_ISR_OFS, 32'h0);
      check(rd & 32'h2, 32'h2);
      wakeup_pin <= (w == 1);
      rtc_alarm <= 1'b0;
      xfer(1'b0, PCM_MODE_OFS, 32'h0);
      check(rd, 32'(PCM_SLOW));
    end
    end_of_test();
  end
endmodule
`default_nettype wire
